// *** fgpio_board.sv ***
// board circuitry model on the gpio pins of every port
// assumes the bench sets the level that outside parts drive on input pins
`timescale 1ns/1ps
`include "fgpio_cfg.svh"
module fgpio_board
	import fgpio_pkg::*;
#(
	parameter int NPORTS = 3
) (
	input  wire logic [NPORTS-1:0][`FGPIO_PW-1:0] pin_out,
	input  wire logic [NPORTS-1:0][`FGPIO_PW-1:0] pin_oe,
	input  wire logic [NPORTS-1:0][`FGPIO_PW-1:0] ext_lvl,
	output logic      [NPORTS-1:0][`FGPIO_PW-1:0] pin_in
);
	// ************************************************************
	// pin level: the device drives where enabled, the board elsewhere
	// ************************************************************
	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			pin_in[p] = (pin_out[p] & pin_oe[p]) | (ext_lvl[p] & ~pin_oe[p]);
		end
	end
endmodule : fgpio_board

// *** fgpio_cfg.svh ***
// constants of the fast gpio block: address map, field layout, resets
// assumes apb byte addresses, 32-bit data, one aligned word per register
`ifndef FGPIO_CFG_SVH
`define FGPIO_CFG_SVH
`define FGPIO_PW          32
`define FGPIO_AW          12
`define FGPIO_SLOTS       8
`define FGPIO_NPORTS      5
`define FGPIO_REGION_PORT 4'h0
`define FGPIO_REGION_EDGE 4'h2
`define FGPIO_REGION_LEG  4'h3
`define FGPIO_OFF_DIR     5'h00
`define FGPIO_OFF_MASK    5'h10
`define FGPIO_OFF_PIN     5'h14
`define FGPIO_OFF_SET     5'h18
`define FGPIO_OFF_CLR     5'h1c
`define FGPIO_OFF_REN     4'h0
`define FGPIO_OFF_FEN     4'h4
`define FGPIO_OFF_RST     4'h8
`define FGPIO_OFF_FST     4'hc
`define FGPIO_LEG_PIN     4'h0
`define FGPIO_LEG_SET     4'h4
`define FGPIO_LEG_DIR     4'h8
`define FGPIO_LEG_CLR     4'hc
`define FGPIO_EDGE_LO     0
`define FGPIO_EDGE_HI     2
`define FGPIO_LEG_PORTS   2
`define FGPIO_RST_WORD    32'h0000_0000
`endif

// *** fgpio_edge.sv ***
// edge interrupt unit of one port: enables, sticky status, wake
// assumes pin levels synchronous; read pulses clear status
`timescale 1ns/1ps
`include "fgpio_cfg.svh"
module fgpio_edge
	import fgpio_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic [`FGPIO_PW-1:0] pin,
	input  wire logic [`FGPIO_PW-1:0] analog,
	input  wire logic                 wr_ren,
	input  wire logic                 wr_fen,
	input  wire logic                 rd_rst,
	input  wire logic                 rd_fst,
	input  wire logic [`FGPIO_PW-1:0] lanes,
	input  wire logic [`FGPIO_PW-1:0] wdata,
	output fgpio_edge_t               st,
	output logic                      irq,
	output logic                      wake
);
	fgpio_edge_t          q;
	logic [`FGPIO_PW-1:0] last_q;
	logic [`FGPIO_PW-1:0] rise_ev;
	logic [`FGPIO_PW-1:0] fall_ev;
	logic [`FGPIO_PW-1:0] ren_d;
	logic [`FGPIO_PW-1:0] fen_d;
	logic [`FGPIO_PW-1:0] rst_d;
	logic [`FGPIO_PW-1:0] fst_d;

	// level compare against the held sample needs no clock edge
	assign rise_ev = pin & ~last_q & ~analog;                      // RULE_07 RULE_08
	assign fall_ev = ~pin & last_q & ~analog;                      // RULE_07 RULE_08
	assign ren_d   = wr_ren ? ((q.rise_en & ~lanes) | (wdata & lanes)) : q.rise_en;
	assign fen_d   = wr_fen ? ((q.fall_en & ~lanes) | (wdata & lanes)) : q.fall_en;
	assign rst_d   = (rd_rst ? `FGPIO_RST_WORD : q.rise_st) | rise_ev; // set wins
	assign fst_d   = (rd_fst ? `FGPIO_RST_WORD : q.fall_st) | fall_ev;
	assign irq     = |((q.rise_st & q.rise_en) | (q.fall_st & q.fall_en)); // RULE_07
	assign wake    = irq | (|((rise_ev & q.rise_en) | (fall_ev & q.fall_en))); // RULE_09
	assign st      = q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q      <= '{`FGPIO_RST_WORD, `FGPIO_RST_WORD, `FGPIO_RST_WORD, `FGPIO_RST_WORD};
			last_q <= `FGPIO_RST_WORD;
		end else begin
			q      <= '{ren_d, fen_d, rst_d, fst_d};
			last_q <= pin;
		end
	end
endmodule : fgpio_edge

// *** fgpio_pkg.sv ***
// types of the fast gpio block
// assumes fgpio_cfg.svh for widths
`include "fgpio_cfg.svh"
package fgpio_pkg;
	typedef struct packed {
		logic [`FGPIO_PW-1:0] dir;
		logic [`FGPIO_PW-1:0] mask;
		logic [`FGPIO_PW-1:0] out;
	} fgpio_port_t;
	typedef struct packed {
		logic [`FGPIO_PW-1:0] rise_en;
		logic [`FGPIO_PW-1:0] fall_en;
		logic [`FGPIO_PW-1:0] rise_st;
		logic [`FGPIO_PW-1:0] fall_st;
	} fgpio_edge_t;
endpackage : fgpio_pkg

// *** fgpio_port.sv ***
// one gpio port: direction, mask and output latch
// assumes write pulses and lane mask come from the apb decode of the top
`timescale 1ns/1ps
`include "fgpio_cfg.svh"
module fgpio_port
	import fgpio_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 wr_dir,
	input  wire logic                 wr_mask,
	input  wire logic                 wr_pin,
	input  wire logic                 wr_set,
	input  wire logic                 wr_clr,
	input  wire logic                 use_mask,
	input  wire logic [`FGPIO_PW-1:0] lanes,
	input  wire logic [`FGPIO_PW-1:0] wdata,
	output fgpio_port_t               cfg
);
	fgpio_port_t          q;
	logic [`FGPIO_PW-1:0] eff;
	logic [`FGPIO_PW-1:0] dir_d;
	logic [`FGPIO_PW-1:0] mask_d;
	logic [`FGPIO_PW-1:0] out_d;

	assign eff    = lanes & (use_mask ? ~q.mask : ~`FGPIO_RST_WORD); // RULE_04 RULE_05
	assign dir_d  = wr_dir ? ((q.dir & ~lanes) | (wdata & lanes)) : q.dir; // RULE_01
	assign mask_d = wr_mask ? ((q.mask & ~lanes) | (wdata & lanes)) : q.mask;
	assign out_d  = wr_pin ? ((q.out & ~eff) | (wdata & eff)) :       // RULE_06
	                wr_set ? (q.out | (wdata & eff)) :                // RULE_02 RULE_13
	                wr_clr ? (q.out & ~(wdata & eff)) : q.out;        // RULE_02 RULE_13
	assign cfg    = q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{`FGPIO_RST_WORD, `FGPIO_RST_WORD, `FGPIO_RST_WORD}; // RULE_10
		end else begin
			q <= '{dir_d, mask_d, out_d};
		end
	end
endmodule : fgpio_port

// *** fgpio_top.sv ***
// fast gpio block: apb slave, ports, edge interrupts, legacy alias
// assumes apb4 master, pins synchronous to clock, one clock domain
//
// Behaviour
// [RULE_01] per-pin direction, changeable any time
// [RULE_02] set and clear registers change groups
// [RULE_03] read output latch and live pins
// [RULE_04] mask limits reads and writes; legacy alias reads and writes ignore the mask
// [RULE_05] byte and half-word lanes honoured
// [RULE_06] one write sets whole port
// [RULE_07] rise/fall edge irq on ports 0, 2
// [RULE_08] edge seen without clock edge
// [RULE_09] enabled edge wakes the chip
// [RULE_10] all pins input after reset
// [RULE_11] legacy alias of ports 0, 1
// [RULE_12] edge irq ored with third external line
// [RULE_13] zero bits of set/clear change nothing
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fgpio_cfg.svh"
module fgpio_top
	import fgpio_pkg::*;
#(
	parameter int NPORTS = `FGPIO_NPORTS
) (
	input  wire logic                               clock,
	input  wire logic                               rst_n,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [`FGPIO_AW-1:0]               paddr,
	input  wire logic [`FGPIO_PW-1:0]               pwdata,
	input  wire logic [3:0]                         pstrb,
	output logic      [`FGPIO_PW-1:0]               prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	input  wire logic [NPORTS-1:0][`FGPIO_PW-1:0]   pin_in,
	output logic      [NPORTS-1:0][`FGPIO_PW-1:0]   pin_out,
	output logic      [NPORTS-1:0][`FGPIO_PW-1:0]   pin_oe,
	input  wire logic [1:0][`FGPIO_PW-1:0]          analog_sel,
	input  wire logic                               third_external_irq_line,
	output logic                                    irq,
	output logic                                    wake
);
	// ****************************************
	// elaboration check
	// ****************************************
	if (NPORTS < 3 || NPORTS > `FGPIO_SLOTS) begin : g_chk
		$error("fgpio_top: NPORTS must be 3..8");
	end

	// ****************************************
	// apb decode
	// ****************************************
	logic                 setup;
	logic                 acc;
	logic                 wr;
	logic                 rd;
	logic [3:0]           region;
	logic [2:0]           pidx;
	logic [4:0]           sub;
	logic [3:0]           off4;
	logic                 blk;
	logic                 sub_ok;
	logic                 hit_port;
	logic                 hit_edge;
	logic                 hit_leg;
	logic                 mapped;
	logic [`FGPIO_PW-1:0] lanes;
	logic [`FGPIO_PW-1:0] prdata_q;
	logic [`FGPIO_PW-1:0] rd_word;
	logic                 is_dir;
	logic                 is_mask;
	logic                 is_pin;
	logic                 is_set;
	logic                 is_clr;
	logic                 is_lpin;
	logic                 is_lset;
	logic                 is_ldir;
	logic                 is_lclr;
	logic                 is_ren;
	logic                 is_fen;
	logic                 is_rst;
	logic                 is_fst;

	assign setup    = psel & ~penable;
	assign acc      = psel & penable;
	assign wr       = acc & pwrite;
	assign rd       = acc & ~pwrite;
	assign region   = paddr[11:8];
	assign pidx     = paddr[7:5];
	assign sub      = paddr[4:0];
	assign off4     = paddr[3:0];
	assign blk      = paddr[4];
	assign is_dir   = (sub == `FGPIO_OFF_DIR);
	assign is_mask  = (sub == `FGPIO_OFF_MASK);
	assign is_pin   = (sub == `FGPIO_OFF_PIN);
	assign is_set   = (sub == `FGPIO_OFF_SET);
	assign is_clr   = (sub == `FGPIO_OFF_CLR);
	assign is_lpin  = (off4 == `FGPIO_LEG_PIN);
	assign is_lset  = (off4 == `FGPIO_LEG_SET);
	assign is_ldir  = (off4 == `FGPIO_LEG_DIR);
	assign is_lclr  = (off4 == `FGPIO_LEG_CLR);
	assign is_ren   = (off4 == `FGPIO_OFF_REN);
	assign is_fen   = (off4 == `FGPIO_OFF_FEN);
	assign is_rst   = (off4 == `FGPIO_OFF_RST);
	assign is_fst   = (off4 == `FGPIO_OFF_FST);
	assign sub_ok   = is_dir | is_mask | is_pin | is_set | is_clr;
	assign hit_port = (region == `FGPIO_REGION_PORT) & ({1'b0, pidx} < 4'(NPORTS)) & sub_ok;
	assign hit_edge = (region == `FGPIO_REGION_EDGE) & (pidx == 3'h0);
	assign hit_leg  = (region == `FGPIO_REGION_LEG) & (pidx == 3'h0);             // RULE_11
	assign mapped   = hit_port | hit_edge | hit_leg;
	assign lanes    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}}; // RULE_05
	assign pready   = 1'b1;
	assign pslverr  = acc & ~mapped;
	assign prdata   = prdata_q;

	// ****************************************
	// ports
	// ****************************************
	fgpio_port_t          po  [`FGPIO_SLOTS];
	logic [`FGPIO_PW-1:0] prw [`FGPIO_SLOTS];
	logic [`FGPIO_PW-1:0] lrw [`FGPIO_SLOTS];

	for (genvar p = 0; p < `FGPIO_SLOTS; p++) begin : g_port
		if (p < NPORTS) begin : g_on
			logic sel;
			logic leg;
			logic w_dir;
			logic w_mask;
			logic w_pin;
			logic w_set;
			logic w_clr;
			assign sel = hit_port & (pidx == 3'(p));
			assign leg = hit_leg & (p < `FGPIO_LEG_PORTS) & (blk == 1'(p));     // RULE_11
			assign w_dir  = wr & ((sel & is_dir) | (leg & is_ldir)); // RULE_01 RULE_11
			assign w_mask = wr & sel & is_mask;                      // RULE_04
			assign w_pin  = wr & ((sel & is_pin) | (leg & is_lpin)); // RULE_06
			assign w_set  = wr & ((sel & is_set) | (leg & is_lset)); // RULE_02
			assign w_clr  = wr & ((sel & is_clr) | (leg & is_lclr)); // RULE_02
			fgpio_port u_port (
				.clock    (clock),
				.rst_n    (rst_n),
				.wr_dir   (w_dir),
				.wr_mask  (w_mask),
				.wr_pin   (w_pin),
				.wr_set   (w_set),
				.wr_clr   (w_clr),
				.use_mask (sel),
				.lanes    (lanes),
				.wdata    (pwdata),
				.cfg      (po[p])
			);
			assign prw[p] = (sub == `FGPIO_OFF_DIR)  ? po[p].dir :
			                (sub == `FGPIO_OFF_MASK) ? po[p].mask :
			                (sub == `FGPIO_OFF_PIN)  ? (pin_in[p] & ~po[p].mask) : // RULE_03 RULE_04
			                (sub == `FGPIO_OFF_SET)  ? po[p].out : `FGPIO_RST_WORD; // RULE_03
			assign lrw[p] = (off4 == `FGPIO_LEG_PIN) ? pin_in[p] :
			                (off4 == `FGPIO_LEG_SET) ? po[p].out :
			                (off4 == `FGPIO_LEG_DIR) ? po[p].dir : `FGPIO_RST_WORD;
			assign pin_out[p] = po[p].out;
			assign pin_oe[p]  = po[p].dir;                                       // RULE_10
		end else begin : g_off
			assign po[p]  = '{`FGPIO_RST_WORD, `FGPIO_RST_WORD, `FGPIO_RST_WORD};
			assign prw[p] = `FGPIO_RST_WORD;
			assign lrw[p] = `FGPIO_RST_WORD;
		end
	end

	// ****************************************
	// edge interrupts on ports 0 and 2
	// ****************************************
	fgpio_edge_t          es   [2];
	logic [1:0]           eirq;
	logic [1:0]           ewak;
	logic [`FGPIO_PW-1:0] erw  [2];

	for (genvar e = 0; e < 2; e++) begin : g_edge
		logic esel;
		logic w_ren;
		logic w_fen;
		logic clr_rst;
		logic clr_fst;
		assign esel    = hit_edge & (blk == 1'(e));
		assign w_ren   = wr & esel & is_ren; // RULE_07
		assign w_fen   = wr & esel & is_fen; // RULE_07
		assign clr_rst = rd & esel & is_rst;
		assign clr_fst = rd & esel & is_fst;
		fgpio_edge u_edge (
			.clock  (clock),
			.rst_n  (rst_n),
			.pin    (pin_in[e ? `FGPIO_EDGE_HI : `FGPIO_EDGE_LO]),
			.analog (analog_sel[e]),
			.wr_ren (w_ren),
			.wr_fen (w_fen),
			.rd_rst (clr_rst),
			.rd_fst (clr_fst),
			.lanes  (lanes),
			.wdata  (pwdata),
			.st     (es[e]),
			.irq    (eirq[e]),
			.wake   (ewak[e])
		);
		assign erw[e] = (off4 == `FGPIO_OFF_REN) ? es[e].rise_en :
		                (off4 == `FGPIO_OFF_FEN) ? es[e].fall_en :
		                (off4 == `FGPIO_OFF_RST) ? es[e].rise_st : es[e].fall_st;
	end

	assign irq  = (|eirq) | third_external_irq_line;                             // RULE_12
	assign wake = |ewak;                                                         // RULE_09

	// ****************************************
	// read data, captured in the setup cycle
	// ****************************************
	assign rd_word = hit_port ? prw[pidx] :
	                 hit_edge ? erw[blk] :
	                 hit_leg  ? lrw[{2'h0, blk}] : `FGPIO_RST_WORD;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= `FGPIO_RST_WORD;
		end else if (setup && !pwrite) begin
			prdata_q <= rd_word;                                                 // RULE_03
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	logic full_wr;
	logic p1_sel;
	assign full_wr = wr & (pstrb == 4'hf);
	assign p1_sel  = hit_port & (pidx == 3'h1);

	property p_dir_write;
		@(posedge clock) disable iff (!rst_n)
		full_wr && p1_sel && is_dir |=> po[1].dir == $past(pwdata) && pin_oe[1] == po[1].dir;
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("dir write not taken"); // RULE_01

	property p_set_bits;
		@(posedge clock) disable iff (!rst_n)
		wr && p1_sel && is_set |=>
			(po[1].out & ($past(pwdata) & ~$past(po[1].mask) & $past(lanes))) ==
			($past(pwdata) & ~$past(po[1].mask) & $past(lanes));
	endproperty
	a_set_bits: assert property (p_set_bits) else $error("set bits not driven high"); // RULE_02

	property p_clr_bits;
		@(posedge clock) disable iff (!rst_n)
		wr && p1_sel && is_clr |=>
			(po[1].out & $past(pwdata) & ~$past(po[1].mask) & $past(lanes)) == `FGPIO_RST_WORD;
	endproperty
	a_clr_bits: assert property (p_clr_bits) else $error("clear bits not driven low"); // RULE_02

	property p_zero_keep;
		@(posedge clock) disable iff (!rst_n)
		wr && p1_sel && (is_set || is_clr) |=>
			((po[1].out ^ $past(po[1].out)) & ~$past(pwdata)) == `FGPIO_RST_WORD;
	endproperty
	a_zero_keep: assert property (p_zero_keep) else $error("zero bit changed the latch"); // RULE_13

	property p_pin_read;
		@(posedge clock) disable iff (!rst_n)
		setup && !pwrite && p1_sel && is_pin ##1 acc |->
			prdata == ($past(pin_in[1]) & ~$past(po[1].mask));
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin read wrong"); // RULE_03

	property p_mask_hold;
		@(posedge clock) disable iff (!rst_n)
		wr && p1_sel && is_pin |=>
			(po[1].out & $past(po[1].mask)) == ($past(po[1].out) & $past(po[1].mask));
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("masked bit changed"); // RULE_04

	property p_lane_hold;
		@(posedge clock) disable iff (!rst_n)
		wr && hit_port && pidx == 3'h2 && is_dir |=>
			(po[2].dir & ~$past(lanes)) == ($past(po[2].dir) & ~$past(lanes));
	endproperty
	a_lane_hold: assert property (p_lane_hold) else $error("unaddressed lane changed"); // RULE_05

	property p_full_word;
		@(posedge clock) disable iff (!rst_n)
		full_wr && p1_sel && is_pin && po[1].mask == `FGPIO_RST_WORD |=>
			pin_out[1] == $past(pwdata);
	endproperty
	a_full_word: assert property (p_full_word) else $error("port not written whole"); // RULE_06

	property p_rise_irq;
		@(posedge clock) disable iff (!rst_n)
		$rose(pin_in[0][0]) && !analog_sel[0][0] && es[0].rise_en[0] |-> wake ##1 es[0].rise_st[0] && irq;
	endproperty
	a_rise_irq: assert property (p_rise_irq) else $error("rising edge missed"); // RULE_07 RULE_08 RULE_09

	property p_reset_input;
		@(posedge clock) $rose(rst_n) |-> pin_oe == '0 ##1 pin_oe == '0 || $past(wr);
	endproperty
	a_reset_input: assert property (p_reset_input) else $error("pin driven after reset"); // RULE_10

	property p_legacy;
		@(posedge clock) disable iff (!rst_n)
		full_wr && hit_leg && blk && is_ldir |=> po[1].dir == $past(pwdata);
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy alias not written"); // RULE_11

	property p_ext_irq;
		@(posedge clock) disable iff (!rst_n)
		third_external_irq_line || eirq != 2'h0 |-> irq;
	endproperty
	a_ext_irq: assert property (p_ext_irq) else $error("irq not raised"); // RULE_12

	property p_irq_quiet;
		@(posedge clock) disable iff (!rst_n)
		!third_external_irq_line && es[0].rise_st == '0 && es[0].fall_st == '0 &&
			es[1].rise_st == '0 && es[1].fall_st == '0 |-> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq raised with no source"); // RULE_12

	property p_fall_irq;
		@(posedge clock) disable iff (!rst_n)
		$fell(pin_in[`FGPIO_EDGE_HI][4]) && !analog_sel[1][4] && es[1].fall_en[4] |->
			wake ##1 es[1].fall_st[4] && irq;
	endproperty
	a_fall_irq: assert property (p_fall_irq) else $error("falling edge missed"); // RULE_07 RULE_09

	property p_analog_quiet;
		@(posedge clock) disable iff (!rst_n)
		$rose(pin_in[0][1]) && analog_sel[0][1] |=> !es[0].rise_st[1] || $past(es[0].rise_st[1]);
	endproperty
	a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin raised status"); // RULE_07

	property p_status_clear;
		@(posedge clock) disable iff (!rst_n)
		rd && hit_edge && !blk && is_rst && pin_in[0] == $past(pin_in[0]) |=> es[0].rise_st == `FGPIO_RST_WORD;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not cleared by read"); // RULE_07

	property p_legacy_pin;
		@(posedge clock) disable iff (!rst_n)
		setup && !pwrite && hit_leg && is_lpin ##1 acc |-> prdata == $past(pin_in[blk]);
	endproperty
	a_legacy_pin: assert property (p_legacy_pin) else $error("legacy pin read wrong"); // RULE_11 RULE_03

	c_set:   cover property (@(posedge clock) disable iff (!rst_n) wr && p1_sel && is_set);
	c_fall:  cover property (@(posedge clock) disable iff (!rst_n) es[1].fall_st != `FGPIO_RST_WORD);
	c_clear: cover property (@(posedge clock) disable iff (!rst_n) rd && hit_edge ##1 !irq);
	c_err:   cover property (@(posedge clock) disable iff (!rst_n) pslverr);
endmodule : fgpio_top

// *** tb.sv ***
// self-checking bench of the fast gpio block over apb
// assumes fgpio_top with three ports and the board model on its pins
`timescale 1ns/1ps
`include "fgpio_cfg.svh"
module tb
	import fgpio_pkg::*;
;
	localparam int NP = 3;
	logic                          clock;
	logic                          rst_n;
	logic                          psel;
	logic                          penable;
	logic                          pwrite;
	logic [`FGPIO_AW-1:0]          paddr;
	logic [`FGPIO_PW-1:0]          pwdata;
	logic [3:0]                    pstrb;
	logic [`FGPIO_PW-1:0]          prdata;
	logic                          pready;
	logic                          pslverr;
	logic [NP-1:0][`FGPIO_PW-1:0]  pin_in;
	logic [NP-1:0][`FGPIO_PW-1:0]  pin_out;
	logic [NP-1:0][`FGPIO_PW-1:0]  pin_oe;
	logic [NP-1:0][`FGPIO_PW-1:0]  ext_lvl;
	logic [1:0][`FGPIO_PW-1:0]     analog_sel;
	logic                          third_external_irq_line;
	logic                          irq;
	logic                          wake;
	int                            error_cnt;
	int                            num_checks;
	int                            cycles;
	logic [31:0]                   rdat;
	logic                          rerr;

	fgpio_top #(.NPORTS(NP)) dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.analog_sel(analog_sel), .third_external_irq_line(third_external_irq_line),
		.irq(irq), .wake(wake));
	fgpio_board #(.NPORTS(NP)) board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
		.pin_in(pin_in));

	// ************************************************************
	// clock and timeout
	// ************************************************************
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles >= 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// ************************************************************
	// apb master and compares
	// ************************************************************
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic chk_bit(input string nm, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %b seen %b", nm, exp, got);
		end
	endtask : chk_bit
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask : wr
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		chk(nm, exp, rdat);
	endtask : rd
	task automatic report_and_stop();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		ext_lvl = '0;
		analog_sel = '0;
		third_external_irq_line = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		cycles = 0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		chk("pin_oe after reset", 32'h0000_0000, pin_oe[0] | pin_oe[1] | pin_oe[2]);
		rd("dir p0 reset", 12'h000, 32'h0000_0000);
		wr(12'h020, 32'hffff_ffff);
		@(negedge clock);
		chk("pin_oe p1", 32'hffff_ffff, pin_oe[1]);
		wr(12'h034, 32'h1234_5678);
		@(negedge clock);
		chk("pin_out p1", 32'h1234_5678, pin_out[1]);
		rd("latch p1", 12'h038, 32'h1234_5678);
		rd("pins p1", 12'h034, 32'h1234_5678);
		wr(12'h038, 32'h0000_00f0);
		wr(12'h03c, 32'h0000_0008);
		rd("set clr p1", 12'h038, 32'h1234_56f0);
		@(negedge clock);
		chk("out set clr p1", 32'h1234_56f0, pin_out[1]);
		wr(12'h030, 32'hffff_0000);
		wr(12'h034, 32'hffff_ffff);
		rd("masked write p1", 12'h038, 32'h1234_ffff);
		rd("masked read p1", 12'h034, 32'h0000_ffff);
		wr(12'h03c, 32'hffff_ffff);
		rd("masked clr p1", 12'h038, 32'h1234_0000);
		wr(12'h020, 32'h0000_0000);
		@(negedge clock);
		chk("pin_oe p1 back", 32'h0000_0000, pin_oe[1]);
		apb(1'b1, 12'h040, 32'haaaa_aaaa, 4'b0010);
		rd("byte lane dir p2", 12'h040, 32'h0000_aa00);
		apb(1'b1, 12'h040, 32'h5555_5555, 4'b1100);
		rd("half lane dir p2", 12'h040, 32'h5555_aa00);
		wr(12'h304, 32'h0000_0005);
		rd("legacy set p0", 12'h018, 32'h0000_0005);
		rd("legacy pin p0", 12'h300, 32'h0000_0000);
		wr(12'h318, 32'h0000_ff00);
		rd("legacy dir p1", 12'h020, 32'h0000_ff00);
		wr(12'h31c, 32'h0004_0000);
		rd("legacy clr p1", 12'h038, 32'h1230_0000);
		apb(1'b0, 12'hff0, 32'h0000_0000, 4'h0);
		chk_bit("unmapped err", 1'b1, rerr);
		// rising edges on port 0, bit 1 analog
		analog_sel[0] <= 32'h0000_0002;
		wr(12'h200, 32'h0000_0003);
		rd("clear rise p0", 12'h208, 32'h0000_0000);
		ext_lvl[0] <= 32'h0000_0003;
		@(negedge clock);
		chk_bit("wake on edge", 1'b1, wake);
		@(negedge clock);
		chk_bit("irq on edge", 1'b1, irq);
		rd("rise status p0", 12'h208, 32'h0000_0001);
		rd("rise status clr", 12'h208, 32'h0000_0000);
		@(negedge clock);
		chk_bit("irq cleared", 1'b0, irq);
		// falling edge on port 2
		wr(12'h214, 32'h0000_0010);
		ext_lvl[2] <= 32'h0000_0010;
		rd("clear fall p2", 12'h21c, 32'h0000_0000);
		chk_bit("no irq on rise", 1'b0, irq);
		ext_lvl[2] <= 32'h0000_0000;
		@(negedge clock);
		chk_bit("wake on fall", 1'b1, wake);
		rd("fall status p2", 12'h21c, 32'h0000_0010);
		@(negedge clock);
		chk_bit("irq fall cleared", 1'b0, irq);
		@(posedge clock);
		third_external_irq_line <= 1'b1;
		@(negedge clock);
		chk_bit("third line irq", 1'b1, irq);
		@(posedge clock);
		third_external_irq_line <= 1'b0;
		@(negedge clock);
		chk_bit("third line low", 1'b0, irq);
		report_and_stop();
	end
endmodule : tb
